// >>> verilog/rsq_pkg.sv
// Shared constants and types of the reset and interrupt sequencer.
package rsq_pkg;
    // ----------------------------------------------------------------
    // Recovery timing, in bus_clock_x4 cycles
    // ----------------------------------------------------------------
    localparam int unsigned STAB_CYC      = 4096;
    localparam int unsigned DELAY_CYC     = 64;
    localparam int unsigned SYNC_CYC      = 3;
    localparam int unsigned WDG_TICK_CYC  = 4080;
    localparam int unsigned WDG_OVF_TICKS = 8;
    localparam int unsigned CNT_KEEP_BITS = 4;
    localparam logic [11:0] CNT_LONG_LAST = 12'(STAB_CYC - 1);
    localparam logic [11:0] CNT_WDG_LAST  = 12'(WDG_TICK_CYC - 1);
    localparam logic [6:0]  DELAY_LOAD    = 7'(DELAY_CYC - 1);
    localparam logic [6:0]  SYNC_LOAD     = 7'(SYNC_CYC - 1);
    localparam logic [3:0]  WDG_LAST      = 4'(WDG_OVF_TICKS - 1);
    localparam logic [15:0] WDG_SVC_ADDR  = 16'hFFFF;

    // ----------------------------------------------------------------
    // Reset cause register layout
    // ----------------------------------------------------------------
    localparam int unsigned CAUSE_POR     = 7;
    localparam int unsigned CAUSE_PIN     = 6;
    localparam int unsigned CAUSE_WDG     = 5;
    localparam int unsigned CAUSE_BADOP   = 4;
    localparam int unsigned CAUSE_BADADDR = 3;
    localparam int unsigned CAUSE_LV      = 1;
    localparam logic [7:0]  CAUSE_RESET   = 8'h80;

    // ----------------------------------------------------------------
    // Interrupt vectors and status flag positions
    // ----------------------------------------------------------------
    localparam int unsigned HW_SRC        = 6;
    localparam logic [15:0] VEC_RESET     = 16'hFFFE;
    localparam logic [15:0] VEC_SWI       = 16'hFFFC;
    localparam logic [15:0] HW_VEC [HW_SRC] = '{16'hFFFA, 16'hFFF6, 16'hFFF4,
                                               16'hFFF2, 16'hFFE0, 16'hFFDE};
    localparam int unsigned HW_FLAG_POS [HW_SRC] = '{1, 3, 4, 5, 14, 15};

    typedef enum {
        ST_STAB, ST_LVHOLD, ST_PINHOLD, ST_DELAY, ST_TAIL, ST_RUN, ST_STOP, ST_WAKE
    } rsq_state_t;
endpackage

// >>> verilog/rsq_cnt_if.sv
// Link between the sequencer and its reset timing counter.
`timescale 1ns/1ns
interface rsq_cnt_if;
    logic        clearAll;
    logic        clearHigh;
    logic        longMode;
    logic        tick;
    logic [11:0] count;

    modport ctl (output clearAll, output clearHigh, output longMode,
                 input tick, input count);
    modport cnt (input clearAll, input clearHigh, input longMode,
                 output tick, output count);
endinterface

// >>> verilog/rsq_timing_counter.sv
// Reset timing counter: twelve counting stages and a terminal stage.
`timescale 1ns/1ns
module rsq_timing_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control link
    rsq_cnt_if.cnt   bus
);
    typedef struct packed {
        logic [11:0] stages;
        logic        stage13;
    } rsq_cnt_state_t;

    rsq_cnt_state_t q;
    rsq_cnt_state_t d;
    logic [11:0]    last;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.stage13 = 1'b0;
        last = bus.longMode ? rsq_pkg::CNT_LONG_LAST : rsq_pkg::CNT_WDG_LAST; // [R7]
        if (bus.clearAll)
        begin
            d.stages = 12'h000;
        end
        else if (q.stages == last)
        begin
            // The terminal stage pulses and clears the chain behind it.
            d.stage13 = 1'b1; // [R14]
            d.stages = 12'h000;
        end
        else if (bus.clearHigh)
        begin
            d.stages = {8'h00, q.stages[rsq_pkg::CNT_KEEP_BITS-1:0]}; // [R6]
        end
        else
        begin
            d.stages = q.stages + 12'h001;
        end
    end

    // The chain runs on the falling edge so it is settled for the sequencer.
    always_ff @(negedge clk or posedge rst) // [R15]
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.tick  = q.stage13;
    assign bus.count = q.stages;

    chk_svc_stages: assert property (@(negedge clk) disable iff (rst) // [R6]
        bus.clearHigh && !bus.clearAll |=> bus.count[11:4] == 8'h00)
        else $error("Service write left upper counter stages set.");

endmodule // rsq_timing_counter

// >>> verilog/rsq_sequencer.sv
// Reset sequencing, reset cause capture, watchdog and interrupt priority.
`timescale 1ns/1ns
// Overview of operation
// [R1] Power-up: reset, clocks off, 4096 cycles, flag
// [R2] Then 64 more cycles before core release
// [R3] Recovery 4163 for long, 67 for others
// [R4] Watchdog overflow resets and sets its flag
// [R5] Internal reset sources drive reset pin low
// [R6] Service write clears watchdog and upper stages
// [R7] Watchdog tick at least every 4080 cycles
// [R8] Break in monitor mode may halt watchdog
// [R9] Illegal opcode sets flag and resets
// [R10] Stop with stop disabled is illegal opcode
// [R11] Only opcode fetch from hole resets
// [R12] Data read from hole never resets
// [R13] Low voltage holds pin, then long recovery
// [R14] Twelve stages plus terminal clearing stage
// [R15] Timing counter advances on falling edge
// [R16] Counter also times stop-mode wake recovery
// [R17] Software interrupt ignores the global mask
// [R18] Software stacks PC, hardware stacks PC-1
// [R19] Fixed priority order with fixed vectors
// [R20] Status flags show each pending source
// [R21] Global mask blocks all but software interrupt
// [R22] Read clears causes; power-up sets only its flag
// [R23] External pin low sets pin cause flag
// [R24] Coincident causes all flagged, one recovery
// [R25] Software services watchdog before it overflows
module rsq_sequencer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Reset pin, open drain
    input  wire logic        rstPinIn,
    output logic             rstPinOut,
    output logic             rstPinOe,
    // Reset sources from the core
    input  wire logic        lowVoltage,
    input  wire logic        illegalOpcode,
    input  wire logic        stopInstr,
    input  wire logic        stopEnable,
    input  wire logic        opcodeFetch,
    input  wire logic        unmappedAccess,
    input  wire logic        busWrite,
    input  wire logic [15:0] busAddr,
    // Debug
    input  wire logic        breakActive,
    input  wire logic        monitorMode,
    input  wire logic        breakWdgDisable,
    // Stop mode
    input  wire logic        stopMode,
    input  wire logic        wakeUp,
    // Reset status
    input  wire logic        causeRead,
    output logic [7:0]       resetCause,
    output logic             coreRst,
    output logic             intBusClkEn,
    // Interrupt sources
    input  wire logic        swiReq,
    input  wire logic        ccrIntMask,
    input  wire logic [15:0] progCnt,
    input  wire logic        extPinIrqFlag,
    input  wire logic        extPinIrqMask,
    input  wire logic        timerCh0Flag,
    input  wire logic        timerCh0IrqEnable,
    input  wire logic        timerCh1Flag,
    input  wire logic        timerCh1IrqEnable,
    input  wire logic        timerOverflowFlag,
    input  wire logic        timerOverflowIrqEnable,
    input  wire logic        keypadFlag,
    input  wire logic        keypadIrqMask,
    input  wire logic        conversionDoneFlag,
    input  wire logic        converterIrqEnable,
    // Interrupt answer
    output logic             intReq,
    output logic [15:0]      intVector,
    output logic [15:0]      stackedPc,
    output logic [15:0]      intStatus
);
    typedef struct packed {
        rsq_pkg::rsq_state_t state;
        logic [6:0]          dly;
        logic [3:0]          wdg;
        logic [2:0]          pinSync;
        logic [2:0]          lvSync;
        logic                pinLow;
        logic                lvHigh;
        logic                pinArmed;
        logic                drvInt;
        logic                cntClr;
        logic                cntSvc;
        logic                longMode;
        logic [7:0]          cause;
        logic                pinOut;
        logic                pinOe;
        logic                coreRst;
        logic                busClk;
        logic                intReq;
        logic [15:0]         vec;
        logic [15:0]         stk;
        logic [15:0]         stat;
    } rsq_seq_state_t;

    localparam rsq_seq_state_t RST_VAL = '{
        state:    rsq_pkg::ST_STAB,
        pinSync:  3'h7,
        drvInt:   1'b1,
        cntClr:   1'b1,
        longMode: 1'b1,
        cause:    rsq_pkg::CAUSE_RESET,
        pinOe:    1'b1,
        coreRst:  1'b1,
        vec:      rsq_pkg::VEC_RESET,
        default:  '0
    };

    rsq_seq_state_t q;
    rsq_seq_state_t s;

    logic                      running;
    logic                      svcHit;
    logic                      wdgHalt;
    logic                      wdgOvf;
    logic                      badOp;
    logic                      badAddr;
    logic                      pinEvt;
    logic                      intEvt;
    logic [7:0]                newCause;
    logic [rsq_pkg::HW_SRC-1:0] hwFlag;
    logic [rsq_pkg::HW_SRC-1:0] hwEn;
    logic [rsq_pkg::HW_SRC-1:0] hwPend;
    logic                      inDelay;
    logic                      inTail;

    rsq_cnt_if cntBus ();

    rsq_timing_counter u_cnt (
        .clk (clk),
        .rst (rst),
        .bus (cntBus.cnt)
    );

    assign cntBus.clearAll  = q.cntClr;
    assign cntBus.clearHigh = q.cntSvc;
    assign cntBus.longMode  = q.longMode; // [R16]

    // ----------------------------------------------------------------
    // Interrupt sources, lowest index wins
    // ----------------------------------------------------------------
    assign hwFlag = {conversionDoneFlag, keypadFlag, timerOverflowFlag,
                     timerCh1Flag, timerCh0Flag, extPinIrqFlag};
    assign hwEn   = {converterIrqEnable, !keypadIrqMask, timerOverflowIrqEnable,
                     timerCh1IrqEnable, timerCh0IrqEnable, !extPinIrqMask};

    for (genvar gi = 0; gi < rsq_pkg::HW_SRC; gi++)
    begin : g_src
        assign hwPend[gi] = hwFlag[gi] & hwEn[gi];
    end

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    assign running = (q.state == rsq_pkg::ST_RUN);
    assign svcHit  = busWrite && (busAddr == rsq_pkg::WDG_SVC_ADDR); // [R6]
    assign wdgHalt = breakActive && monitorMode && breakWdgDisable; // [R8]
    assign badOp   = running && (illegalOpcode || (stopInstr && !stopEnable)); // [R9] [R10]
    // A data access to a hole is ignored; only a confirmed opcode fetch counts.
    assign badAddr = running && opcodeFetch && unmappedAccess; // [R11] [R12]
    assign pinEvt  = running && q.pinArmed && q.pinLow; // [R23]
    assign intEvt  = wdgOvf || badOp || badAddr;
    assign inDelay = (q.state == rsq_pkg::ST_DELAY);
    assign inTail  = (q.state == rsq_pkg::ST_TAIL);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s = q;
        wdgOvf = 1'b0;
        newCause = 8'h00;
        s.pinSync = {q.pinSync[1:0], rstPinIn};
        s.lvSync = {q.lvSync[1:0], lowVoltage};
        if (q.pinSync[1] == q.pinSync[2])
        begin
            s.pinLow = !q.pinSync[2];
        end
        if (q.lvSync[1] == q.lvSync[2])
        begin
            s.lvHigh = q.lvSync[2];
        end
        s.cntClr = 1'b0;
        s.cntSvc = running && svcHit; // [R6]

        // Watchdog counts prescaled ticks only while the core runs.
        if (!running || svcHit)
        begin
            s.wdg = 4'h0; // [R6]
        end
        else if (cntBus.tick && !wdgHalt) // [R7] [R8]
        begin
            if (q.wdg == rsq_pkg::WDG_LAST)
            begin
                wdgOvf = 1'b1; // [R4]
                s.wdg = 4'h0;
            end
            else
            begin
                s.wdg = q.wdg + 4'h1;
            end
        end

        newCause[rsq_pkg::CAUSE_WDG] = wdgOvf; // [R4]
        newCause[rsq_pkg::CAUSE_BADOP] = badOp; // [R9] [R10]
        newCause[rsq_pkg::CAUSE_BADADDR] = badAddr; // [R11]
        newCause[rsq_pkg::CAUSE_LV] = q.lvHigh; // [R13]
        newCause[rsq_pkg::CAUSE_PIN] = pinEvt; // [R23]
        // A new cause in the reading cycle survives the clear.
        s.cause = (causeRead ? 8'h00 : q.cause) | newCause; // [R22] [R24]

        case (q.state)
            rsq_pkg::ST_STAB:
            begin
                if (cntBus.tick && !q.cntClr) // [R1]
                begin
                    s.state = rsq_pkg::ST_DELAY;
                    s.dly = rsq_pkg::DELAY_LOAD; // [R2]
                end
            end
            rsq_pkg::ST_LVHOLD:
            begin
                if (!q.lvHigh)
                begin
                    s.state = rsq_pkg::ST_STAB; // [R13]
                    s.cntClr = 1'b1;
                end
            end
            rsq_pkg::ST_PINHOLD:
            begin
                if (!q.pinLow)
                begin
                    s.state = rsq_pkg::ST_DELAY;
                    s.dly = rsq_pkg::DELAY_LOAD;
                end
            end
            rsq_pkg::ST_DELAY:
            begin
                if (q.dly == 7'h00)
                begin
                    s.state = rsq_pkg::ST_TAIL; // [R3]
                    s.dly = rsq_pkg::SYNC_LOAD;
                end
                else
                begin
                    s.dly = q.dly - 7'h01;
                end
            end
            rsq_pkg::ST_TAIL:
            begin
                if (q.dly == 7'h00)
                begin
                    s.state = rsq_pkg::ST_RUN;
                end
                else
                begin
                    s.dly = q.dly - 7'h01;
                end
            end
            rsq_pkg::ST_RUN:
            begin
                if (pinEvt)
                begin
                    s.state = rsq_pkg::ST_PINHOLD; // [R23]
                    s.drvInt = 1'b0;
                end
                else if (stopMode)
                begin
                    s.state = rsq_pkg::ST_STOP;
                end
            end
            rsq_pkg::ST_STOP:
            begin
                if (wakeUp)
                begin
                    s.state = rsq_pkg::ST_WAKE;
                    s.cntClr = 1'b1;
                end
            end
            rsq_pkg::ST_WAKE:
            begin
                if (cntBus.tick && !q.cntClr) // [R16]
                begin
                    s.state = rsq_pkg::ST_RUN;
                end
            end
            default:
            begin
                s.state = rsq_pkg::ST_STAB;
            end
        endcase

        // Low voltage outranks everything and chooses the long recovery.
        if (q.lvHigh)
        begin
            s.state = rsq_pkg::ST_LVHOLD; // [R13] [R24]
            s.drvInt = 1'b1;
        end
        else if (intEvt)
        begin
            s.state = rsq_pkg::ST_DELAY; // [R3] [R24]
            s.dly = rsq_pkg::DELAY_LOAD;
            s.drvInt = 1'b1;
        end

        s.coreRst = !(s.state inside {rsq_pkg::ST_RUN, rsq_pkg::ST_STOP,
                                      rsq_pkg::ST_WAKE});
        s.pinOut = 1'b0;
        s.pinOe = (s.state inside {rsq_pkg::ST_STAB, rsq_pkg::ST_LVHOLD}) ||
                  (s.state == rsq_pkg::ST_DELAY && s.drvInt); // [R5]
        s.longMode = s.state inside {rsq_pkg::ST_STAB, rsq_pkg::ST_LVHOLD,
                                     rsq_pkg::ST_WAKE};
        s.busClk = !(s.state inside {rsq_pkg::ST_STAB, rsq_pkg::ST_LVHOLD,
                                     rsq_pkg::ST_STOP, rsq_pkg::ST_WAKE}); // [R1] [R16]
        // Our own drive is seen late through the synchroniser, so the pin
        // only counts once it has been seen high after release.
        if (s.pinOe)
        begin
            s.pinArmed = 1'b0;
        end
        else if (!q.pinLow)
        begin
            s.pinArmed = 1'b1;
        end

        s.stat = 16'h0000;
        for (int i = 0; i < rsq_pkg::HW_SRC; i++)
        begin
            s.stat[rsq_pkg::HW_FLAG_POS[i]] = hwPend[i]; // [R20]
        end

        s.intReq = 1'b0;
        if (s.coreRst)
        begin
            s.vec = rsq_pkg::VEC_RESET; // [R19]
        end
        else if (swiReq)
        begin
            s.intReq = 1'b1; // [R17]
            s.vec = rsq_pkg::VEC_SWI;
            s.stk = progCnt; // [R18]
        end
        else if (!ccrIntMask && (|hwPend)) // [R21]
        begin
            s.intReq = 1'b1;
            s.stk = progCnt - 16'h0001; // [R18]
            for (int i = rsq_pkg::HW_SRC - 1; i >= 0; i--)
            begin
                if (hwPend[i])
                begin
                    s.vec = rsq_pkg::HW_VEC[i]; // [R19]
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= RST_VAL; // [R1] [R22]
        end
        else
        begin
            q <= s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rstPinOut   = q.pinOut;
    assign rstPinOe    = q.pinOe;
    assign resetCause  = q.cause;
    assign coreRst     = q.coreRst;
    assign intBusClkEn = q.busClk;
    assign intReq      = q.intReq;
    assign intVector   = q.vec;
    assign stackedPc   = q.stk;
    assign intStatus   = q.stat;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_por_hold: assert property (q.state == rsq_pkg::ST_STAB |-> // [R1]
        !intBusClkEn && rstPinOe && coreRst)
        else $error("Stabilisation phase left clocks on or pin free.");
    chk_delay_len: assert property ($rose(inTail) |-> // [R2]
        $past(inDelay, 64) && !$past(inDelay, 65))
        else $error("Release delay is not 64 cycles.");
    chk_tail_len: assert property ($fell(coreRst) |-> // [R3]
        $past(inTail, 3) && !$past(inTail, 4))
        else $error("Final recovery tail is not 3 cycles.");
    chk_wdg_reset: assert property (wdgOvf |=> // [R4] [R5]
        resetCause[rsq_pkg::CAUSE_WDG] && rstPinOe && coreRst)
        else $error("Watchdog overflow did not reset.");
    chk_svc_clear: assert property (svcHit |=> q.wdg == 4'h0) // [R6]
        else $error("Service write did not clear watchdog.");
    chk_brk_halt: assert property (running && wdgHalt && !svcHit |=> // [R8]
        $stable(q.wdg))
        else $error("Watchdog advanced while halted by break.");
    chk_bad_op: assert property (badOp && !q.lvHigh |=> // [R9] [R10]
        resetCause[rsq_pkg::CAUSE_BADOP] && rstPinOe && inDelay)
        else $error("Illegal opcode did not reset.");
    chk_fetch_hole: assert property (badAddr |=> // [R11]
        resetCause[rsq_pkg::CAUSE_BADADDR] && coreRst)
        else $error("Opcode fetch from hole did not reset.");
    chk_data_hole: assert property (running && unmappedAccess && !opcodeFetch && // [R12]
        !illegalOpcode && !stopInstr && !wdgOvf && !q.lvHigh && !pinEvt && !stopMode
        |=> !coreRst)
        else $error("Data access to hole caused a reset.");
    chk_lv_hold: assert property (q.lvHigh |=> // [R13]
        rstPinOe && resetCause[rsq_pkg::CAUSE_LV] && q.state == rsq_pkg::ST_LVHOLD)
        else $error("Low voltage did not hold reset.");
    chk_swi_any: assert property (swiReq && !s.coreRst |=> // [R17] [R18]
        intReq && intVector == rsq_pkg::VEC_SWI && stackedPc == $past(progCnt))
        else $error("Software interrupt not taken correctly.");
    chk_mask_all: assert property (ccrIntMask && !swiReq |=> !intReq) // [R21]
        else $error("Masked hardware interrupt was raised.");
    chk_read_clear: assert property (causeRead && newCause == 8'h00 |=> // [R22]
        resetCause == 8'h00)
        else $error("Reading causes did not clear them.");

    cov_por_done: cover property ($fell(coreRst));
    cov_swi: cover property (intReq && intVector == rsq_pkg::VEC_SWI);
    cov_lv: cover property (q.state == rsq_pkg::ST_LVHOLD);
    cov_pin: cover property (q.state == rsq_pkg::ST_PINHOLD);

endmodule // rsq_sequencer

// >>> test/rsq_pin_model.sv
// Reset pin wire model: pull-up, device pull-down and an outside push-button.
`timescale 1ns/1ns
module rsq_pin_model (
    // Device side
    input  wire logic oe,
    input  wire logic outVal,
    // Outside side
    input  wire logic extLow,
    // Wire level
    output logic      pinLevel
);
    // The pull-up wins only when nobody pulls low, so a release shows high at once.
    assign pinLevel = !((oe && !outVal) || extLow);
endmodule // rsq_pin_model

// >>> test/rsq_sequencer_tb_top.sv
// Self-checking bench of the reset and interrupt sequencer.
`timescale 1ns/1ns
module rsq_sequencer_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pinIn, pinOut, pinOe, coreRst, clkEn, intReq;
    logic        extLow = 1'b0, lowV = 1'b0, badOp = 1'b0, stopI = 1'b0, stopEn = 1'b1;
    logic        fetch = 1'b0, hole = 1'b0, wr = 1'b0, rd = 1'b0, software_interrupt_instruction = 1'b0, ext_pin_irq_mask = 1'b0;
    logic        brk = 1'b0, stopM = 1'b0, wake = 1'b0;
    logic [15:0] addr = 16'h0000, pc = 16'h1234, vec, spc, stat, expStat;
    logic [5:0]  flg = 6'h00, ena = 6'h00;
    logic [7:0]  cause;
    int          n_fail = 0;
    int          checks_done = 0;

    always #50 clk = ~clk;

    rsq_pin_model u_pin (.oe(pinOe), .outVal(pinOut), .extLow(extLow), .pinLevel(pinIn));

    rsq_sequencer u_dut (.clk(clk), .rst(rst), .rstPinIn(pinIn), .rstPinOut(pinOut),
        .rstPinOe(pinOe), .lowVoltage(lowV), .illegalOpcode(badOp), .stopInstr(stopI),
        .stopEnable(stopEn), .opcodeFetch(fetch), .unmappedAccess(hole), .busWrite(wr),
        .busAddr(addr), .breakActive(brk), .monitorMode(brk), .breakWdgDisable(brk),
        .stopMode(stopM), .wakeUp(wake), .causeRead(rd), .resetCause(cause),
        .coreRst(coreRst), .intBusClkEn(clkEn), .swiReq(software_interrupt_instruction), .ccrIntMask(ext_pin_irq_mask),
        .progCnt(pc), .extPinIrqFlag(flg[0]), .extPinIrqMask(!ena[0]),
        .timerCh0Flag(flg[1]), .timerCh0IrqEnable(ena[1]), .timerCh1Flag(flg[2]),
        .timerCh1IrqEnable(ena[2]), .timerOverflowFlag(flg[3]),
        .timerOverflowIrqEnable(ena[3]), .keypadFlag(flg[4]), .keypadIrqMask(!ena[4]),
        .conversionDoneFlag(flg[5]), .converterIrqEnable(ena[5]), .intReq(intReq),
        .intVector(vec), .stackedPc(spc), .intStatus(stat));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Counts falling edges until coreRst shows the wanted level; a hang ends the run.
    task automatic wait_rst(input logic lvl, input int lim, output int n);
        n = 0;
        while (coreRst !== lvl)
        begin
            @(negedge clk);
            n++;
            if (n > lim)
            begin
                n_fail++;
                close_out();
            end
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    initial
    begin
        int n;
        repeat (16) @(negedge clk);
        check(cause, 16'h0080);
        check({pinOe, clkEn, coreRst}, 16'h5);
        rst = 1'b0;
        wait_rst(1'b0, 5000, n);
        check(n >= 4160 && n <= 4166, 16'h1);
        check(pinIn, 16'h1);
        $display("test power_on done");
        hole = 1'b1;
        repeat (3) @(negedge clk);
        check(coreRst, 16'h0);
        pulse(fetch);
        hole = 1'b0;
        check({pinOe, coreRst}, 16'h3);
        wait_rst(1'b0, 100, n);
        check(n >= 65 && n <= 68, 16'h1);
        check(cause, 16'h0088);
        pulse(rd);
        check(cause, 16'h0000);
        pulse(badOp);
        wait_rst(1'b0, 100, n);
        check(cause, 16'h0010);
        pulse(rd);
        stopEn = 1'b0;
        fetch = 1'b1;
        hole = 1'b1;
        pulse(stopI);
        fetch = 1'b0;
        hole = 1'b0;
        wait_rst(1'b0, 100, n);
        check(n >= 65 && n <= 68, 16'h1);
        check(cause, 16'h0018);
        $display("test bad_access done");
        software_interrupt_instruction = 1'b1;
        ext_pin_irq_mask = 1'b1;
        flg = 6'h3F;
        ena = 6'h3F;
        @(negedge clk);
        check(intReq, 16'h1);
        check(vec, 16'hFFFC);
        check(spc, pc);
        software_interrupt_instruction = 1'b0;
        @(negedge clk);
        check(intReq, 16'h0);
        ext_pin_irq_mask = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            flg = 6'h3F << i;
            expStat = 16'h0000;
            for (int j = i; j < 6; j++)
                expStat[rsq_pkg::HW_FLAG_POS[j]] = 1'b1;
            @(negedge clk);
            check(vec, rsq_pkg::HW_VEC[i]);
            check(stat, expStat);
            check(spc, pc - 16'h0001);
        end
        flg = 6'h00;
        $display("test interrupts done");
        stopM = 1'b1;
        @(negedge clk);
        stopM = 1'b0;
        check({clkEn, coreRst}, 16'h0);
        pulse(wake);
        repeat (4090) @(negedge clk);
        check(clkEn, 16'h0);
        repeat (12) @(negedge clk);
        check({clkEn, coreRst}, 16'h2);
        pulse(rd);
        addr = rsq_pkg::WDG_SVC_ADDR;
        brk = 1'b1;
        pulse(wr);
        repeat (9000) @(negedge clk);
        check(coreRst, 16'h0);
        brk = 1'b0;
        wait_rst(1'b1, 40000, n);
        // Two prescaler ticks fall inside the break, so ten ticks pass before overflow.
        check(n > 31784 && n <= 31804, 16'h1);
        check({cause, pinOe}, 16'h0041);
        check(pinIn, 16'h0);
        wait_rst(1'b0, 100, n);
        check(n >= 65 && n <= 68, 16'h1);
        extLow = 1'b1;
        repeat (6) @(negedge clk);
        extLow = 1'b0;
        wait_rst(1'b0, 100, n);
        check(cause, 16'h0060);
        lowV = 1'b1;
        repeat (20) @(negedge clk);
        check({coreRst, pinOe}, 16'h3);
        lowV = 1'b0;
        wait_rst(1'b0, 5000, n);
        check(n >= 4160 && n <= 4172, 16'h1);
        check(cause, 16'h0062);
        $display("test watchdog_pin_voltage done");
        close_out();
    end
endmodule // rsq_sequencer_tb_top
